// [src/nph_pkg.sv]
// Package for the packet metadata header offload block.
// Assumes one clock domain; holds header layout, codes and sizing figures.
package nph_pkg;

   // ----------------------------------------------------------------
   // Header layout
   // ----------------------------------------------------------------
   localparam int unsigned NPH_HDR_BYTES      = 12;
   localparam int unsigned NPH_HDR_HASH_BYTES = 20;
   localparam int unsigned NPH_FLG_NEEDS_CSUM = 0;
   localparam int unsigned NPH_FLG_DATA_VALID = 1;
   localparam int unsigned NPH_FLG_COAL_INFO  = 2;

   // ----------------------------------------------------------------
   // Segmentation type codes
   // ----------------------------------------------------------------
   localparam logic [7:0] NPH_SEG_NONE  = 8'h00;
   localparam logic [7:0] NPH_SEG_TCP4  = 8'h01;
   localparam logic [7:0] NPH_SEG_UDPF  = 8'h03;
   localparam logic [7:0] NPH_SEG_TCP6  = 8'h04;
   localparam logic [7:0] NPH_SEG_UDPS  = 8'h05;
   localparam logic [7:0] NPH_SEG_ECN   = 8'h80;

   // ----------------------------------------------------------------
   // Receive sizing
   // ----------------------------------------------------------------
   localparam logic [16:0] NPH_MAX_PKT_LARGE = 17'h10035; // 65589 bytes.
   localparam logic [16:0] NPH_MAX_PKT_SMALL = 17'h005ea; // 1514 bytes.
   localparam logic [15:0] NPH_NUMBUF_ONE    = 16'h0001;
   localparam logic [15:0] NPH_ZERO16        = 16'h0000;

   // Negotiated feature set.
   typedef struct packed {
      logic tx_csum;
      logic host_tso4;
      logic host_tso6;
      logic host_ufo;
      logic host_uso;
      logic host_ecn;
      logic exact_hdrlen;
      logic guest_lro;
      logic mrg_rxbuf;
      logic hash_report;
      logic rsc_ext;
   } nph_feat_t;

   // Metadata header, fields in wire order.
   typedef struct packed {
      logic [7:0]  flags;
      logic [7:0]  seg_type;
      logic [15:0] hdr_len;
      logic [15:0] seg_size;
      logic [15:0] csum_start;
      logic [15:0] csum_off;
      logic [15:0] num_bufs;
   } nph_hdr_t;

   // Decoded transmit request for the packet engine.
   typedef struct packed {
      logic        do_csum;
      logic [15:0] csum_start;
      logic [15:0] csum_off;
      logic        do_seg;
      logic [2:0]  seg_kind;
      logic        seg_ecn;
      logic        hdr_len_trusted;
      logic [15:0] hdr_len;
      logic [15:0] seg_size;
      logic        trust_pkt_csum;
   } nph_txreq_t;

   // Little-endian 16-bit field taken from two header bytes.
   function automatic logic [15:0] nph_le16(input logic [7:0] lo, input logic [7:0] hi);
      nph_le16 = {hi, lo};
   endfunction : nph_le16

endpackage : nph_pkg

// [src/nph_hdr_parse.sv]
// Byte-serial parser that collects a 12-byte metadata header.
// Assumes bytes arrive in wire order with a start marker on byte zero.
`timescale 1ns/100ps
`default_nettype none
module nph_hdr_parse (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   // Byte stream in.
   input  wire logic             byte_vld_i,
   input  wire logic             byte_sop_i,
   input  wire logic [7:0]       byte_i,
   // Assembled header out.
   output logic                  hdr_vld_o,
   output nph_pkg::nph_hdr_t     hdr_o
);
   import nph_pkg::*;

   logic [3:0]  idx_ff;
   logic [7:0]  buf_ff [0:11];
   logic        vld_ff;

   // ----------------------------------------------------------------
   // Byte collection
   // ----------------------------------------------------------------
   // A start marker always restarts the index so a torn header recovers.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idx_ff <= 4'h0;
         vld_ff <= 1'b0;
         for (int i = 0; i < 12; i++) begin
            buf_ff[i] <= 8'h00;
         end
      end else begin
         vld_ff <= 1'b0;
         if (byte_vld_i) begin
            if (byte_sop_i) begin
               buf_ff[0] <= byte_i;
               idx_ff    <= 4'h1;
            end else if (idx_ff != 4'h0 && idx_ff < 4'(NPH_HDR_BYTES)) begin
               buf_ff[idx_ff] <= byte_i;
               idx_ff         <= (idx_ff == 4'(NPH_HDR_BYTES - 1)) ? 4'h0 : idx_ff + 4'h1;
               vld_ff         <= (idx_ff == 4'(NPH_HDR_BYTES - 1));
            end
         end
      end
   end

   // Field assembly, low byte first.
   assign hdr_vld_o        = vld_ff;
   assign hdr_o.flags      = buf_ff[0];
   assign hdr_o.seg_type   = buf_ff[1];
   assign hdr_o.hdr_len    = nph_le16(buf_ff[2], buf_ff[3]);
   assign hdr_o.seg_size   = nph_le16(buf_ff[4], buf_ff[5]);
   assign hdr_o.csum_start = nph_le16(buf_ff[6], buf_ff[7]);
   assign hdr_o.csum_off   = nph_le16(buf_ff[8], buf_ff[9]);
   assign hdr_o.num_bufs   = nph_le16(buf_ff[10], buf_ff[11]);

endmodule : nph_hdr_parse
`default_nettype wire

// [src/nph_offload.sv]
// Transmit header interpreter and receive header builder.
// Assumes features are stable while traffic flows; one 40 MHz clock.
// How it works
// [RULE1] Driver transmit header matches receive header size. Parser takes 12 bytes even when hash report makes receive 20.
// [RULE2] No checksum offload: driver flags are zero.
// [RULE3] Segmentation types only with matching host feature.
// [RULE4] ECN segmented TCP needs host ECN bit.
// [RULE5] Driver validates earlier checksums, sets start, offset.
// [RULE6] Driver preloads pseudo-header sum into checksum.
// [RULE7] No host segmentation: type is always none.
// [RULE8] Segmentation implies needs-checksum and segment size.
// [RULE9] Exact header length given when negotiated.
// [RULE10] Otherwise header length at least full headers.
// [RULE11] Driver never sets data-valid or coalescing flags.
// [RULE12] Device ignores unknown transmit flag bits.
// [RULE13] Checksum fields ignored without needs-checksum.
// [RULE14] Exact header length trusted, but bounded.
// [RULE15] Otherwise header length is only a hint.
// [RULE16] No needs-checksum: embedded checksum not trusted.
// [RULE17] Max packet 65589 large, else 1514.
// [RULE18] Unmerged receive buffers sized 1526 or 65601. With hash report the code gives 1534 or 65609.
// [RULE19] Merged buffers hold at least one header.
// [RULE20] Buffer count is descriptors used; one unmerged.
// [RULE21] Only first buffer carries the header.
// [RULE22] Coalescing sets flag, counts in checksum fields.
// [RULE23] Header fields in order, little-endian words.
// [RULE24] Segmentation type codes and ECN modifier bit.
`timescale 1ns/100ps
`default_nettype none
module nph_offload #(
   parameter int unsigned MAX_BUFS = 64
) (
   // Clock and reset.
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   // Negotiated features.
   input  wire nph_pkg::nph_feat_t   feat_i,
   // Transmit header byte stream.
   input  wire logic                 tx_byte_vld_i,
   input  wire logic                 tx_byte_sop_i,
   input  wire logic [7:0]           tx_byte_i,
   // Decoded transmit request.
   output logic                      tx_req_vld_o,
   output nph_pkg::nph_txreq_t       tx_req_o,
   // Receive packet description from the engine.
   input  wire logic                 rx_pkt_vld_i,
   input  wire logic [16:0]          rx_pkt_len_i,
   input  wire logic [15:0]          rx_buf_len_i,
   input  wire logic                 rx_csum_part_i,
   input  wire logic                 rx_csum_ok_i,
   input  wire logic [15:0]          rx_csum_start_i,
   input  wire logic [15:0]          rx_csum_off_i,
   input  wire logic [7:0]           rx_seg_type_i,
   input  wire logic [15:0]          rx_seg_size_i,
   input  wire logic [15:0]          rx_hdr_len_i,
   input  wire logic [15:0]          rx_coal_segs_i,
   input  wire logic [15:0]          rx_dup_acks_i,
   // Built receive header and placement.
   output logic                      rx_hdr_vld_o,
   output nph_pkg::nph_hdr_t         rx_hdr_o,
   output logic                      rx_drop_o,
   output logic [16:0]               rx_max_pkt_o,
   output logic [16:0]               rx_min_buf_o
);
   import nph_pkg::*;

   // Elaboration-time guard: the count field and its compare serve 1 to 65535 buffers.
   if (MAX_BUFS < 1 || MAX_BUFS > 65535) begin : g_bad_max_bufs
      $error("MAX_BUFS out of range");
   end

   // ----------------------------------------------------------------
   // Transmit header interpretation
   // ----------------------------------------------------------------
   logic       hdr_vld;
   nph_hdr_t   hdr;
   logic       host_seg;
   logic [2:0] seg_kind;

   nph_hdr_parse u_parse (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .byte_vld_i(tx_byte_vld_i),
      .byte_sop_i(tx_byte_sop_i),
      .byte_i    (tx_byte_i), // [RULE23]
      .hdr_vld_o (hdr_vld),
      .hdr_o     (hdr)
   );

   assign host_seg = feat_i.host_tso4 | feat_i.host_tso6 | feat_i.host_ufo | feat_i.host_uso;
   // ECN modifier is masked off before the kind is decoded.
   assign seg_kind = hdr.seg_type[2:0] & {3{(hdr.seg_type & ~NPH_SEG_ECN) <= NPH_SEG_UDPS}}; // [RULE24]

   // Hardware cannot harden the driver's own obligations, so only the
   // fields this end consumes are shaped here; other bits are dropped.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_req_vld_o <= 1'b0;
         tx_req_o     <= '0;
      end else begin
         tx_req_vld_o <= hdr_vld;
         if (hdr_vld) begin
            // Only the needs-checksum bit is read; others ignored.
            tx_req_o.do_csum        <= hdr.flags[NPH_FLG_NEEDS_CSUM]; // [RULE12]
            tx_req_o.csum_start     <= hdr.flags[NPH_FLG_NEEDS_CSUM] ? hdr.csum_start
                                                                      : NPH_ZERO16; // [RULE13]
            tx_req_o.csum_off       <= hdr.flags[NPH_FLG_NEEDS_CSUM] ? hdr.csum_off
                                                                      : NPH_ZERO16; // [RULE13]
            tx_req_o.trust_pkt_csum <= 1'b0; // [RULE16]
            tx_req_o.do_seg         <= host_seg && seg_kind != 3'(NPH_SEG_NONE); // [RULE7]
            tx_req_o.seg_kind       <= seg_kind;
            tx_req_o.seg_ecn        <= hdr.seg_type[7] & feat_i.host_ecn; // [RULE4]
            tx_req_o.seg_size       <= hdr.seg_size;
            // Exact length trusted only when negotiated and the header gives a segmentation type,
            // and then only while it is below the largest packet; the length itself passes unchanged.
            tx_req_o.hdr_len_trusted <= feat_i.exact_hdrlen && seg_kind != 3'h0
                                        && {1'b0, hdr.hdr_len} < NPH_MAX_PKT_LARGE; // [RULE14]
            tx_req_o.hdr_len        <= hdr.hdr_len; // [RULE15]
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive sizing
   // ----------------------------------------------------------------
   logic [16:0] max_pkt;
   logic [16:0] hdr_bytes;
   assign max_pkt   = feat_i.guest_lro ? NPH_MAX_PKT_LARGE : NPH_MAX_PKT_SMALL; // [RULE17]
   assign hdr_bytes = feat_i.hash_report ? 17'(NPH_HDR_HASH_BYTES) : 17'(NPH_HDR_BYTES);

   // Smallest buffer the driver ought to post for this feature set.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_max_pkt_o <= NPH_MAX_PKT_SMALL;
         rx_min_buf_o <= 17'h0;
      end else begin
         rx_max_pkt_o <= max_pkt;
         rx_min_buf_o <= feat_i.mrg_rxbuf ? hdr_bytes : max_pkt + hdr_bytes; // [RULE18]
      end
   end

   // ----------------------------------------------------------------
   // Receive header build
   // ----------------------------------------------------------------
   logic [16:0] total;
   logic [16:0] nbufs;
   logic        fits;
   assign total = rx_pkt_len_i + hdr_bytes;
   // Buffer count by ceiling division; header only in the first buffer.
   // The sum is one bit wider so a large packet in large buffers cannot wrap the count.
   assign nbufs = (rx_buf_len_i == 16'h0) ? 17'h1fff
                : 17'(({1'b0, total} + {2'b00, rx_buf_len_i} - 18'h00001)
                      / {2'b00, rx_buf_len_i}); // [RULE21]
   // A buffer below header size cannot be used when merging.
   assign fits  = (rx_pkt_len_i <= max_pkt)
                && ({1'b0, rx_buf_len_i} >= hdr_bytes) // [RULE19]
                && (feat_i.mrg_rxbuf ? nbufs <= 17'(MAX_BUFS) : total <= {1'b0, rx_buf_len_i});

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_hdr_vld_o <= 1'b0;
         rx_drop_o    <= 1'b0;
         rx_hdr_o     <= '0;
      end else begin
         rx_hdr_vld_o <= rx_pkt_vld_i & fits;
         rx_drop_o    <= rx_pkt_vld_i & ~fits;
         if (rx_pkt_vld_i) begin
            rx_hdr_o.flags <= {5'h0,
                               feat_i.rsc_ext, // [RULE22]
                               rx_csum_ok_i & ~rx_csum_part_i,
                               rx_csum_part_i | (rx_seg_type_i != NPH_SEG_NONE)};
            rx_hdr_o.seg_type   <= rx_seg_type_i;
            rx_hdr_o.hdr_len    <= rx_hdr_len_i;
            rx_hdr_o.seg_size   <= rx_seg_size_i;
            rx_hdr_o.csum_start <= feat_i.rsc_ext ? rx_coal_segs_i : rx_csum_start_i; // [RULE22]
            rx_hdr_o.csum_off   <= feat_i.rsc_ext ? rx_dup_acks_i : rx_csum_off_i; // [RULE22]
            rx_hdr_o.num_bufs   <= feat_i.mrg_rxbuf ? nbufs[15:0] : NPH_NUMBUF_ONE; // [RULE20]
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_csum_ignored: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE13]
      hdr_vld && !hdr.flags[0] |=> tx_req_o.csum_start == 16'h0 && tx_req_o.csum_off == 16'h0)
      else $error("checksum fields used without needs-checksum");
   a_no_trust: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE16]
      tx_req_vld_o |-> !tx_req_o.trust_pkt_csum)
      else $error("embedded checksum trusted");
   a_unknown_flags: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE12]
      hdr_vld |=> tx_req_vld_o && tx_req_o.do_csum == $past(hdr.flags[0]))
      else $error("flag bits caused a refusal");
   a_hint_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE15]
      hdr_vld && !feat_i.exact_hdrlen |=> !tx_req_o.hdr_len_trusted)
      else $error("header length trusted without exact length");
   a_bounded_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE14]
      tx_req_vld_o && tx_req_o.hdr_len_trusted |-> {1'b0, tx_req_o.hdr_len} < 17'h10035)
      else $error("trusted header length unbounded");
   a_one_buf: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE20]
      rx_pkt_vld_i && !feat_i.mrg_rxbuf |=> rx_hdr_o.num_bufs == 16'h1)
      else $error("buffer count not one");
   a_coal_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE22]
      rx_pkt_vld_i && feat_i.rsc_ext |=> rx_hdr_o.flags[2] && rx_hdr_o.csum_start == $past(rx_coal_segs_i))
      else $error("coalescing info not reported");
   a_max_pkt: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE17]
      rx_pkt_vld_i && rx_pkt_len_i > max_pkt |=> rx_drop_o && !rx_hdr_vld_o)
      else $error("oversize packet accepted");
   a_small_buf: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE19]
      rx_pkt_vld_i && {1'b0, rx_buf_len_i} < hdr_bytes |=> rx_drop_o && !rx_hdr_vld_o)
      else $error("buffer below header size accepted");

   // A header that asks for a checksum gives a request that keeps its offset.
   sequence s_csum_hdr;
      hdr_vld && hdr.flags[NPH_FLG_NEEDS_CSUM];
   endsequence
   sequence s_csum_req;
      tx_req_vld_o && tx_req_o.do_csum;
   endsequence
   a_csum_kept: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE13]
      s_csum_hdr |=> s_csum_req ##0 (tx_req_o.csum_off == $past(hdr.csum_off)))
      else $error("checksum offset lost with needs-checksum");
   a_req_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE23]
      !hdr_vld |=> !tx_req_vld_o)
      else $error("request without a complete header");
   a_seg_code: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE24]
      tx_req_vld_o && tx_req_o.do_seg |-> tx_req_o.seg_kind inside {3'h1, 3'h3, 3'h4, 3'h5})
      else $error("segmentation of an unknown kind");
   a_rsc_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE22]
      rx_pkt_vld_i && !feat_i.rsc_ext |=> !rx_hdr_o.flags[NPH_FLG_COAL_INFO])
      else $error("coalescing flag set without the feature");
   a_first_hdr: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE21]
      rx_hdr_vld_o |-> rx_hdr_o.num_bufs != NPH_ZERO16)
      else $error("accepted packet with no buffer");

endmodule : nph_offload
`default_nettype wire

// [testbench/nph_drv_model.sv]
// Guest driver model that serialises transmit metadata headers onto the byte stream.
// Assumes the bench calls send_hdr; bytes change on falling clock edges only.
`timescale 1ns/100ps
`default_nettype none
module nph_drv_model (
   // Clock and negotiated features.
   input  wire logic               mclk_i,
   input  wire nph_pkg::nph_feat_t feat_i,
   // Header byte stream.
   output logic                    byte_vld_o,
   output logic                    byte_sop_o,
   output logic [7:0]              byte_o
);
   import nph_pkg::*;

   // The stream is idle until the first header.
   initial begin
      byte_vld_o = 1'b0;
      byte_sop_o = 1'b0;
      byte_o     = 8'h00;
   end

   // Cleans the header as a careful driver would; only the junk argument and, with hash report, the 12-byte size break a rule.
   task automatic send_hdr(inout nph_hdr_t h, input logic [7:0] junk, input logic last);
      logic [95:0] w;
      logic        ok;
      case (h.seg_type[6:0])
         7'h01: ok = feat_i.host_tso4;
         7'h03: ok = feat_i.host_ufo;
         7'h04: ok = feat_i.host_tso6;
         7'h05: ok = feat_i.host_uso;
         default: ok = 1'b0;
      endcase
      // Segmenting needs checksum offload as well, so without it the type stays none.
      if (!ok || !feat_i.tx_csum) h.seg_type = NPH_SEG_NONE;
      if (!feat_i.host_ecn || !(h.seg_type[2:0] inside {3'h1, 3'h4})) h.seg_type[7] = 1'b0;
      if (!feat_i.tx_csum) h.flags = 8'h00;
      // No payload is modelled: a set needs-checksum flag stands for a packet whose
      // checksum field holds the pseudo-header sum, with earlier checksums valid.
      if (h.seg_type != NPH_SEG_NONE) h.flags[NPH_FLG_NEEDS_CSUM] = 1'b1;
      h.flags[NPH_FLG_COAL_INFO:NPH_FLG_DATA_VALID] = 2'b00;
      h.num_bufs = NPH_ZERO16;
      h.flags = h.flags | (junk & 8'hf8);
      w = h;
      // Twelve bytes, words low byte first; the header size matches the receive one only without hash report, which makes that one 20.
      // The caller's header length is taken as the exact length of its headers.
      for (int i = 0; i < 12; i++) begin
         @(negedge mclk_i);
         byte_vld_o = 1'b1;
         byte_sop_o = (i == 0);
         byte_o     = (i < 2) ? w[95-8*i -: 8] : w[79-16*((i-2)/2)-8*((i+1)%2) -: 8];
      end
      // A released data line shows a changing value, never the last byte.
      if (last) begin
         @(negedge mclk_i);
         byte_vld_o = 1'b0;
         byte_sop_o = 1'b0;
         byte_o     = ~byte_o;
      end
   endtask : send_hdr
endmodule : nph_drv_model
`default_nettype wire

// [testbench/net_packet_header_offload_test.sv]
// Self-checking bench for the metadata header offload block.
// Assumes the package, the design and the driver model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module net_packet_header_offload_test;
   import nph_pkg::*;
   // ---------------------------------------------------------------
   // Signals and queues
   // ---------------------------------------------------------------
   localparam int unsigned MAXB = 4;
   logic        mclk_i, sys_rst_i, tb_vld, tb_sop, rx_pkt_vld_i, rx_csum_part_i, rx_csum_ok_i;
   logic        tx_req_vld_o, rx_hdr_vld_o, rx_drop_o;
   logic [7:0]  tb_byte, rx_seg_type_i;
   logic [15:0] rx_buf_len_i, rx_csum_start_i, rx_csum_off_i, rx_seg_size_i, rx_hdr_len_i;
   logic [15:0] rx_coal_segs_i, rx_dup_acks_i, rnd;
   logic [16:0] rx_pkt_len_i, rx_max_pkt_o, rx_min_buf_o;
   nph_feat_t   feat;
   nph_txreq_t  tx_req_o;
   nph_hdr_t    rx_hdr_o, h;
   logic [71:0] txq [$];
   logic [51:0] rxq [$];
   logic [71:0] et, gt;
   logic [51:0] er, gr;
   int          n_mismatch, checks_done;
   logic [7:0]  seg_tab [5] = '{NPH_SEG_NONE, NPH_SEG_TCP4, NPH_SEG_UDPF, NPH_SEG_TCP6, NPH_SEG_UDPS};

   nph_drv_model drv (.mclk_i(mclk_i), .feat_i(feat), .byte_vld_o(tb_vld), .byte_sop_o(tb_sop),
      .byte_o(tb_byte));
   nph_offload #(.MAX_BUFS(MAXB)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .feat_i(feat),
      .tx_byte_vld_i(tb_vld), .tx_byte_sop_i(tb_sop), .tx_byte_i(tb_byte),
      .tx_req_vld_o(tx_req_vld_o), .tx_req_o(tx_req_o), .rx_pkt_vld_i(rx_pkt_vld_i),
      .rx_pkt_len_i(rx_pkt_len_i), .rx_buf_len_i(rx_buf_len_i), .rx_csum_part_i(rx_csum_part_i),
      .rx_csum_ok_i(rx_csum_ok_i), .rx_csum_start_i(rx_csum_start_i), .rx_csum_off_i(rx_csum_off_i),
      .rx_seg_type_i(rx_seg_type_i), .rx_seg_size_i(rx_seg_size_i), .rx_hdr_len_i(rx_hdr_len_i),
      .rx_coal_segs_i(rx_coal_segs_i), .rx_dup_acks_i(rx_dup_acks_i), .rx_hdr_vld_o(rx_hdr_vld_o),
      .rx_hdr_o(rx_hdr_o), .rx_drop_o(rx_drop_o), .rx_max_pkt_o(rx_max_pkt_o),
      .rx_min_buf_o(rx_min_buf_o));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] nxt_rand(input logic [15:0] s);
      nxt_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt_rand
   function automatic logic [16:0] hb();
      hb = feat.hash_report ? 17'h00014 : 17'h0000c;
   endfunction : hb
   function automatic logic [16:0] mx();
      mx = feat.guest_lro ? NPH_MAX_PKT_LARGE : NPH_MAX_PKT_SMALL;
   endfunction : mx
   // Level and sizing results; the other compares funnel through here.
   task automatic chk_lvl(input logic [71:0] got, input logic [71:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_lvl
   task automatic chk_tx(input logic [71:0] got, input logic [71:0] exp);
      chk_lvl(got, exp);
   endtask : chk_tx
   task automatic chk_rx(input logic [51:0] got, input logic [51:0] exp);
      chk_lvl(72'(got), 72'(exp));
   endtask : chk_rx
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   // Sends one header and notes the decoded request the block should give.
   task automatic tx_hdr(input nph_hdr_t hi, input logic [7:0] junk, input logic last);
      nph_hdr_t w;
      logic     dc, sg;
      w = hi;
      drv.send_hdr(w, junk, last);
      dc = w.flags[NPH_FLG_NEEDS_CSUM];
      sg = (w.seg_type[2:0] != 3'h0);
      txq.push_back({dc, dc ? w.csum_start : 16'h0000, dc ? w.csum_off : 16'h0000, sg,
         w.seg_type[2:0], w.seg_type[7], w.hdr_len, w.seg_size, feat.exact_hdrlen & sg, 1'b0});
   endtask : tx_hdr
   // One receive packet pulse; drop and buffer count follow the sizing figures.
   task automatic rx_pkt(input logic [16:0] len, input logic [15:0] bl);
      logic [17:0] tot, nb;
      logic        drop;
      @(negedge mclk_i);
      rnd = nxt_rand(rnd);
      {rx_pkt_vld_i, rx_pkt_len_i, rx_buf_len_i} = {1'b1, len, bl};
      {rx_csum_part_i, rx_csum_ok_i, rx_seg_type_i} = {rnd[1:0], rnd[2] ? NPH_SEG_TCP4 : NPH_SEG_NONE};
      {rx_csum_start_i, rx_csum_off_i, rx_seg_size_i, rx_hdr_len_i} = {4{rnd}};
      {rx_coal_segs_i, rx_dup_acks_i} = {8'h00, rnd[15:8], 12'h000, rnd[3:0]};
      tot = len + hb();
      nb = (tot + bl - 18'h00001) / bl;
      drop = (len > mx()) || (bl < hb()) || (feat.mrg_rxbuf ? nb > MAXB : tot > bl);
      rxq.push_back({drop, drop ? 3'h0 : {feat.rsc_ext, rnd[0] & ~rnd[1], rnd[1] | rnd[2]},
         drop ? 16'h0000 : (feat.mrg_rxbuf ? nb[15:0] : NPH_NUMBUF_ONE),
         (drop | ~feat.rsc_ext) ? 32'h0 : {rx_coal_segs_i, rx_dup_acks_i}});
   endtask : rx_pkt
   // Waits a bounded time for every noted result; leftovers end the run.
   task automatic drain();
      for (int n = 0; n < 50 && (txq.size() + rxq.size()) > 0; n++) @(posedge mclk_i);
      chk_lvl(72'(txq.size() + rxq.size()), 72'h0);
      if ((txq.size() + rxq.size()) > 0) close_out();
      @(negedge mclk_i);
   endtask : drain
   // ---------------------------------------------------------------
   // Clock, result watcher and main sequence
   // ---------------------------------------------------------------
   always #12.5 mclk_i = ~mclk_i;
   // Takes the oldest note off a queue whenever the block shows a result.
   always @(negedge mclk_i) begin
      if (tx_req_vld_o === 1'b1) begin
         et = (txq.size() > 0) ? txq.pop_front() : '1;
         gt = {tx_req_o.do_csum, tx_req_o.csum_start, tx_req_o.csum_off, tx_req_o.do_seg,
            tx_req_o.do_seg ? tx_req_o.seg_kind : 3'h0, tx_req_o.seg_ecn, tx_req_o.hdr_len,
            tx_req_o.seg_size, tx_req_o.hdr_len_trusted, tx_req_o.trust_pkt_csum & ~tx_req_o.do_csum};
         chk_tx(gt, et);
      end
      if ((rx_hdr_vld_o | rx_drop_o) === 1'b1) begin
         er = (rxq.size() > 0) ? rxq.pop_front() : '1;
         gr = {rx_drop_o, rx_drop_o ? 3'h0 : rx_hdr_o.flags[2:0], rx_drop_o ? 16'h0 : rx_hdr_o.num_bufs,
            (rx_drop_o | ~er[50]) ? 32'h0 : {rx_hdr_o.csum_start, rx_hdr_o.csum_off}};
         chk_rx(gr, er);
      end
   end
   // Reset, sizing, three transmit feature sets, then three receive set-ups.
   initial begin
      {mclk_i, sys_rst_i, feat, rnd, n_mismatch, checks_done} = {2'b01, 11'h000, 16'h0047, 64'h0};
      {rx_pkt_vld_i, rx_pkt_len_i, rx_buf_len_i, rx_csum_part_i, rx_csum_ok_i, rx_seg_type_i} = '0;
      {rx_csum_start_i, rx_csum_off_i, rx_seg_size_i, rx_hdr_len_i, rx_coal_segs_i, rx_dup_acks_i} = '0;
      repeat (20) @(negedge mclk_i);
      chk_lvl({rx_max_pkt_o, rx_min_buf_o, tx_req_vld_o, rx_drop_o}, {NPH_MAX_PKT_SMALL, 19'h0});
      sys_rst_i = 1'b0;
      for (int c = 0; c < 8; c++) begin
         {feat.hash_report, feat.mrg_rxbuf, feat.guest_lro} = c[2:0];
         repeat (3) @(negedge mclk_i);
         chk_lvl({rx_max_pkt_o, rx_min_buf_o}, {mx(), c[1] ? hb() : mx() + hb()});
      end
      $display("test reset and sizing done");
      for (int p = 0; p < 3; p++) begin
         feat = p ? '0 : '1;
         if (p == 2) feat = rnd[10:0];
         for (int i = 0; i < 10; i++) begin
            rnd = nxt_rand(rnd);
            h = {rnd[7:0], seg_tab[i % 5] | (rnd[8] ? NPH_SEG_ECN : 8'h00), rnd ^ 16'h1234, rnd,
               rnd ^ 16'h00ff, rnd ^ 16'hff00, 16'h0000};
            tx_hdr(h, rnd[15:8], i == 9);
         end
         drain();
         $display("test transmit set %0d done", p);
      end
      for (int p = 0; p < 3; p++) begin
         feat = '0;
         {feat.rsc_ext, feat.hash_report, feat.guest_lro, feat.mrg_rxbuf} = {p[0], p[0], p[1], p == 2};
         for (int i = 0; i < 16; i++) begin
            rnd = nxt_rand(rnd);
            rx_pkt(feat.mrg_rxbuf ? {8'h00, rnd[8:0]} : mx() - 17'h00008 + rnd[3:0],
               feat.mrg_rxbuf ? {8'h00, rnd[15:9], 1'b1} : 16'(mx() + hb() - 17'h00004 + rnd[6:4]));
         end
         @(negedge mclk_i);
         rx_pkt_vld_i = 1'b0;
         drain();
         $display("test receive set %0d done", p);
      end
      close_out();
   end
endmodule : net_packet_header_offload_test
`default_nettype wire
